// file: logic/active_exception_status.sv
// Module: active exception status register with Wishbone slave
//
// Design decisions made here: the Wishbone slave port and the register addresses.
`default_nettype none
module active_exception_status
   import aes_pkg::*;
(
   input  wire logic         clk_sys,
   input  wire logic         reset_n,
   input  wire logic [5:0]   handler_exception_number,
   input  wire logic [63:0]  active_set,
   input  wire logic [5:0]   pending_vector_in,
   input  wire logic [31:0]  wb_adr_i,
   input  wire logic [31:0]  wb_dat_i,
   input  wire logic [3:0]   wb_sel_i,
   input  wire logic         wb_we_i,
   input  wire logic         wb_cyc_i,
   input  wire logic         wb_stb_i,
   output var  logic [31:0]  wb_dat_o,
   output var  logic         wb_ack_o,
   output var  logic [5:0]   active_vector_number,
   output var  logic         return_to_base_flag,
   output var  logic [5:0]   pending_vector_number
);
   import aes_pkg::*;

   exc_state_if st ();
   logic [5:0] next_active;
   logic [5:0] next_pending;
   logic [5:0] irq_index;

   // ***************************************************
   // Status capture
   // ***************************************************
   // Reserved numbers map to none rather than leaking out
   function automatic logic [5:0] legal_vec(input logic [5:0] v);
      if (v > EXC_IRQ_LAST) begin
         return EXC_NONE;
      end
      return v;
   endfunction : legal_vec

   assign next_active  = legal_vec(handler_exception_number);
   assign next_pending = legal_vec(pending_vector_in);
   assign st.current   = next_active;
   assign st.active    = active_set;

   exc_scan u_scan (
      .s (st)
   );

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         active_vector_number  <= ACT_RESET;
         return_to_base_flag   <= RET_RESET;
         pending_vector_number <= EXC_NONE;
      end else begin
         active_vector_number  <= next_active;
         return_to_base_flag   <= st.only_one;
         pending_vector_number <= next_pending;
      end
   end

   // Peripheral index helper; zero outside handler range
   assign irq_index = (active_vector_number >= IRQ_OFFSET) ?
                      6'(active_vector_number - IRQ_OFFSET) : 6'h00;

   // ***************************************************
   // Wishbone slave
   // ***************************************************
   // Writes are acknowledged but change nothing
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         wb_dat_o <= READ_UNMAPPED;
      end else if (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i) begin
         unique case (wb_adr_i[3:0])
            ADDR_STATUS: begin
               wb_dat_o <= {14'h0000, pending_vector_number, return_to_base_flag,
                            5'h00, active_vector_number};
            end
            ADDR_IRQ_VIEW: begin
               wb_dat_o <= {26'h000_0000, irq_index};
            end
            default: begin
               wb_dat_o <= READ_UNMAPPED;
            end
         endcase
      end else begin
         wb_dat_o <= wb_dat_o;
      end
   end
endmodule : active_exception_status
`default_nettype wire

// file: include/aes_pkg.sv
// Package: encodings, field layout and offsets for the active exception status block
`default_nettype none
package aes_pkg;
   // ***************************************************
   // Exception number encoding
   // ***************************************************
   localparam int          VEC_W              = 6;
   localparam logic [5:0]  EXC_NONE           = 6'h00;
   localparam logic [5:0]  EXC_NMI            = 6'h02;
   localparam logic [5:0]  EXC_HARD_FAULT     = 6'h03;
   localparam logic [5:0]  EXC_FAULT_LAST     = 6'h06;
   localparam logic [5:0]  EXC_SERVICE_REQ    = 6'h0E;
   localparam logic [5:0]  EXC_TICK_TIMER     = 6'h0F;
   localparam logic [5:0]  EXC_IRQ_BASE       = 6'h10;
   localparam logic [5:0]  EXC_IRQ_LAST       = 6'h3B;
   localparam int          NUM_EXC            = 64;
   localparam int          NUM_IRQ            = 44;
   localparam logic [5:0]  IRQ_OFFSET         = 6'h10;
   // ***************************************************
   // Status register layout
   // ***************************************************
   localparam int          ACT_LSB            = 0;
   localparam int          RET_BIT            = 11;
   localparam int          PEND_LSB           = 12;
   localparam logic        RET_RESET          = 1'b0;
   localparam logic [5:0]  ACT_RESET          = 6'h00;
   // ***************************************************
   // Bus map
   // ***************************************************
   localparam logic [3:0]  ADDR_STATUS        = 4'h0;
   localparam logic [3:0]  ADDR_IRQ_VIEW      = 4'h4;
   localparam logic [31:0] READ_UNMAPPED      = 32'h0000_0000;
endpackage : aes_pkg
`default_nettype wire

// file: include/exc_state_if.sv
// Interface: active-set view handed from the top to the scanner
`default_nettype none
interface exc_state_if;
   logic [63:0] active;
   logic [5:0]  current;
   logic        only_one;
   modport scan (input active, input current, output only_one);
   modport top  (output active, output current, input only_one);
endinterface : exc_state_if
`default_nettype wire

// file: logic/exc_scan.sv
// Module: flags whether any active exception above EXC_FAULT_LAST and up to EXC_IRQ_LAST besides the current one exists
`default_nettype none
module exc_scan
   import aes_pkg::*;
(
   exc_state_if.scan s
);
   logic others;

   // NMI and faults never block return to base
   always_comb begin
      others = 1'b0;
      for (int i = 0; i < NUM_EXC; i++) begin
         if (s.active[i] && (i > int'(EXC_FAULT_LAST)) && (6'(i) != s.current) &&
             (6'(i) <= EXC_IRQ_LAST)) begin
            others = 1'b1;
         end
      end
      s.only_one = !others;
   end
endmodule : exc_scan
`default_nettype wire

// file: dv/aes_checker.sv
// Checker: port-level assertions for the active exception status block
`default_nettype none
module aes_checker
   import aes_pkg::*;
(
   input wire logic        clk_sys,
   input wire logic        reset_n,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_ack_o,
   input wire logic        return_to_base_flag,
   input wire logic [5:0]  handler_exception_number,
   input wire logic [5:0]  pending_vector_in,
   input wire logic [5:0]  active_vector_number,
   input wire logic [5:0]  pending_vector_number,
   input wire logic [63:0] active_set,
   input wire logic [31:0] wb_dat_o
);
   logic [63:0] others;
   // Faults, NMI and reserved numbers never block a return to base
   assign others = active_set & 64'h0FFF_FFFF_FFFF_FF80 & ~(64'h0000_0000_0000_0001 << handler_exception_number);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   AST_ACT: assert property ($past(reset_n) |-> active_vector_number ==
      ($past(handler_exception_number) > EXC_IRQ_LAST ? EXC_NONE : $past(handler_exception_number))) else $error("act");
   AST_PEND: assert property ($past(reset_n) |-> pending_vector_number ==
      ($past(pending_vector_in) > EXC_IRQ_LAST ? EXC_NONE : $past(pending_vector_in))) else $error("pend");
   AST_RSV: assert property (active_vector_number <= EXC_IRQ_LAST && pending_vector_number <= EXC_IRQ_LAST)
      else $error("reserved number");
   AST_RET_LOW: assert property ($past(reset_n) && $past(others) != 0 |-> !return_to_base_flag)
      else $error("ret high");
   AST_RET_HIGH: assert property ($past(reset_n) && $past(others) == 0 |-> return_to_base_flag)
      else $error("ret low");
   AST_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
   AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack long");
   AST_ACK_CAUSE: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i)) else $error("stray ack");
   AST_RD_RSVD: assert property (wb_ack_o |-> wb_dat_o[31:18] == 14'h0 && wb_dat_o[10:6] == 5'h0)
      else $error("reserved bits");
   C_ACK: cover property (wb_ack_o);
   C_RET: cover property ($fell(return_to_base_flag));
   C_TOP: cover property (active_vector_number == EXC_IRQ_LAST);
endmodule : aes_checker
bind active_exception_status aes_checker u_chk (.*);
`default_nettype wire

// file: dv/active_exception_status_tb_top.sv
// Testbench: status traffic and Wishbone reads against a reference model
`default_nettype none
module active_exception_status_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import aes_pkg::*;
   logic        clk_sys = 0, reset_n = 0, wb_we_i = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_ack_o, return_to_base_flag;
   logic [5:0]  handler_exception_number = 0, pending_vector_in = 0, active_vector_number, pending_vector_number;
   logic [63:0] active_set = 0;
   logic [31:0] wb_adr_i = 0, wb_dat_i = 0, wb_dat_o, rd;
   logic [3:0]  wb_sel_i = 4'hF;
   int          num_errors = 0, total_checks = 0, seed = 32'h2829, am, pm, rm;
   active_exception_status dut (.*);
   initial forever #2.5 clk_sys = ~clk_sys;
   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         num_errors++;
         $display("[ERR] %s exp %h got %h", n, e, g);
      end
   endtask : chk
   task automatic bus(logic w, logic [31:0] a);
      int n;
      n = 0;
      @(posedge clk_sys);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, 32'($random(seed))};
      do @(posedge clk_sys);
      while (wb_ack_o !== 1'b1 && ++n < 20);
      if (n >= 20) num_errors++;
      rd = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'b00;
   endtask : bus
   task automatic complete_run;
      if (num_errors == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : complete_run
   initial begin
      repeat (5) @(posedge clk_sys);
      chk("ret_rst", 0, return_to_base_flag);
      chk("act_rst", 0, active_vector_number);
      reset_n <= 1;
      for (int i = 0; i < 128; i++) begin
         handler_exception_number <= i[5:0];
         pending_vector_in <= 6'($random(seed));
         // First half keeps only numbers up to EXC_FAULT_LAST and the running one, so bit 11 sees both values
         active_set <= {$random(seed), $random(seed)} & (i[6] ? '1 : (64'h1 << i[5:0]) | 64'h7F);
         @(posedge clk_sys);
         @(negedge clk_sys);
         am = handler_exception_number > EXC_IRQ_LAST ? 0 : handler_exception_number;
         pm = pending_vector_in > EXC_IRQ_LAST ? 0 : pending_vector_in;
         rm = (active_set & 64'h0FFF_FFFF_FFFF_FF80 & ~(64'h1 << handler_exception_number)) == 0;
         chk("act", am, active_vector_number);
         chk("pend", pm, pending_vector_number);
         chk("ret", rm, return_to_base_flag);
         bus(i[0], 0);
         bus(0, 0);
         chk("status", {pm[5:0], rm[0], 5'h0, am[5:0]}, rd);
         bus(0, 4);
         chk("view", am >= 16 ? am - 16 : 0, rd);
         bus(0, 32'h0000_0008);
         chk("unmapped", 0, rd);
      end
      complete_run();
   end
   initial begin
      repeat (20000) @(posedge clk_sys);
      num_errors++;
      complete_run();
   end
endmodule : active_exception_status_tb_top
`default_nettype wire
